// file: verilog/atg_defs.svh
// register offsets, field positions and reset values of the ADC controller
`ifndef ATG_DEFS_SVH
`define ATG_DEFS_SVH

// register byte addresses; only the low address bits are decoded
`define ATG_ADDR_MASK    32'h000000fc
`define ATG_OFF_TIMING   32'hbfe74000
`define ATG_OFF_SCTL     32'hbfe74004
`define ATG_OFF_CCTL     32'hbfe74008
`define ATG_OFF_XWIN     32'hbfe74010
`define ATG_OFF_YWIN     32'hbfe74014
`define ATG_OFF_GWIN     32'hbfe74018
`define ATG_OFF_COORD    32'hbfe74020
`define ATG_OFF_SRES_HI  32'hbfe74020
`define ATG_OFF_SRES_LO  32'hbfe74024
`define ATG_OFF_CRES     32'hbfe74028
`define ATG_OFF_SETTLE   32'hbfe7402c
`define ATG_OFF_IRQ      32'hbfe74030

// reset values
`define ATG_RST_TIMING   32'h00400010
`define ATG_RST_WIN      32'h03ff0000
`define ATG_RST_GWIN     32'h03f0000f
`define ATG_RST_SETTLE   20'h00640

// field positions
`define ATG_DIV_HI       31
`define ATG_DIV_LO       20
`define ATG_GAP_HI       19
`define ATG_HI_HI        25
`define ATG_HI_LO        16
`define ATG_LO_HI        9
`define ATG_S_HALT       6
`define ATG_S_SRST       5
`define ATG_S_START      4
`define ATG_C_RUN        7
`define ATG_C_TOUCH      6
`define ATG_C_FIVE       5
`define ATG_C_GUARD      4
`define ATG_I_EMPTY      9
`define ATG_BUSY         31

// bus answers
`define ATG_RESP_OKAY    2'b00
`define ATG_RESP_SLVERR  2'b10

`endif

// file: verilog/atg_pkg.sv
// types shared by the ADC controller
package atg_pkg;

	// conversion sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_START,
		SEQ_WAIT
	} atg_seq_e;

	// drive towards the converter macro
	typedef struct packed {
		logic       clk;
		logic       power;
		logic       start;
		logic [1:0] chan;
	} atg_conv_req_s;

endpackage

// file: verilog/atg_controller.sv
// ADC controller: AXI4-Lite registers, conversion sequencer, touch, guard
`timescale 1ns/100ps
`default_nettype none
`include "atg_defs.svh"

// Functional notes
// - conversion clock is system clock divided by timing[31:20].
// - continuous rounds are spaced by timing[19:0] conversion clock ticks.
// - halt bit stops all conversions and powers the converter off.
// - writing soft-reset resets the controller; bit clears itself.
// - writing start begins single conversion; start bit clears itself.
// - busy sets on start write, clears after all single conversions.
// - four-bit single channel mask; several bits scan all chosen channels.
// - continuous runs until cleared; software stops it before changing channels.
// - touch_panel_on selects touch mode; five_wire_select picks five wire.
// - guard on: flag results above upper or below lower bound.
// - touch press judged by X and Y min/max windows.
// - coordinates register holds X high field, Y low field.
// - single results: ch0/ch1 low/high of one word, ch2/ch3 of other.
// - continuous results packed two per word, ascending channel order; an odd last result goes alone.
// - continuous results go to DMA; touch coordinates do not.
// - each new result overwrites coordinates and continuous result.
// - singles may be inserted on unused channels during continuous.
// - press and release latch touch_down and touch_up flags.
// - the five status flags clear when software writes one.
// - four enables mask full, guard, release and press interrupts.
// - touch press/release accepted after settle_count delay, reset 0x640.
// - read-only fifo_empty shows the continuous buffer is empty.
// - overrunning single insertion postpones the next continuous round.
module atg_controller (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	output var atg_pkg::atg_conv_req_s conv_req,
	input  wire logic                 conv_done,
	input  wire logic [9:0]           conv_data,
	output logic [31:0]               dma_data,
	output logic                      dma_valid,
	input  wire logic                 dma_ready,
	output logic                      irq
);

	//--------------------------------------------------------------
	// declarations
	//--------------------------------------------------------------
	logic        soft_q, rst;
	logic        aw_have, w_have, wr_do;
	logic [31:0] aw_addr_q, w_data_q, rd_val;
	logic [3:0]  w_strb_q;
	logic        rd_ok;
	logic [31:0] timing, xwin, ywin, gwin, wr_merged;
	logic        halt, start_q;
	logic [3:0]  smask;
	logic [7:0]  cctl;
	logic [19:0] settle;
	logic [3:0]  irq_en;
	logic [4:0]  flags, flag_set, flag_clr;
	logic [11:0] div_cnt;
	logic        tick;
	logic [19:0] gap_cnt;
	logic        due, due_take;
	atg_pkg::atg_seq_e state;
	logic [3:0]  s_pend, c_left, round_mask, start_set;
	logic        job_cont, single_busy;
	logic [2:0]  done_s;
	logic        done_lvl, done_prev, cap, round_end;
	logic [9:0]  sres [4];
	logic [9:0]  pack_lo, x_axis, y_axis;
	logic        half;
	logic [31:0] cres;
	logic        raw_touch, pressed;
	logic [19:0] settle_cnt;

	// register addressing helpers, used by both the read and the write decode
	function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
		return (a & `ATG_ADDR_MASK) == (o & `ATG_ADDR_MASK);
	endfunction

	// lowest set channel of a mask
	function automatic logic [1:0] low_chan(input logic [3:0] m);
		logic [1:0] c;
		c = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (m[i]) begin
				c = 2'(i);
			end
		end
		return c;
	endfunction

	//--------------------------------------------------------------
	// soft reset and AXI4-Lite slave
	//--------------------------------------------------------------
	// bus handshake survives soft reset so the pending answer still arrives
	assign rst = !aresetn || soft_q;

	// write: address and data taken in any order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ATG_RESP_OKAY;
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_addr_q     <= 32'h00000000;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have       <= 1'b1;
				s_axi_awready <= 1'b0;
				aw_addr_q     <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have       <= 1'b1;
				s_axi_wready <= 1'b0;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= rd_ok_w(aw_addr_q) ? `ATG_RESP_OKAY
				                                   : `ATG_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end
	assign wr_do = aw_have && w_have && !s_axi_bvalid;

	// writable or readable offsets answer OKAY, the rest SLVERR
	function automatic logic rd_ok_w(input logic [31:0] a);
		return hit(a, `ATG_OFF_TIMING) || hit(a, `ATG_OFF_SCTL)
		    || hit(a, `ATG_OFF_CCTL) || hit(a, `ATG_OFF_XWIN)
		    || hit(a, `ATG_OFF_YWIN) || hit(a, `ATG_OFF_GWIN)
		    || hit(a, `ATG_OFF_SRES_HI) || hit(a, `ATG_OFF_SRES_LO)
		    || hit(a, `ATG_OFF_CRES) || hit(a, `ATG_OFF_SETTLE)
		    || hit(a, `ATG_OFF_IRQ);
	endfunction

	// read: one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `ATG_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_val;
				s_axi_rresp   <= rd_ok ? `ATG_RESP_OKAY : `ATG_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// read mux; the shared offset shows coordinates only in touch mode
	always_comb begin
		rd_val = 32'h00000000;
		rd_ok  = rd_ok_w(s_axi_araddr);
		if (hit(s_axi_araddr, `ATG_OFF_TIMING))
			rd_val = timing;
		if (hit(s_axi_araddr, `ATG_OFF_SCTL))
			rd_val = {25'h0000000, halt, soft_q, start_q, smask};
		if (hit(s_axi_araddr, `ATG_OFF_CCTL))
			rd_val = {24'h000000, cctl};
		if (hit(s_axi_araddr, `ATG_OFF_XWIN))
			rd_val = xwin;
		if (hit(s_axi_araddr, `ATG_OFF_YWIN))
			rd_val = ywin;
		if (hit(s_axi_araddr, `ATG_OFF_GWIN))
			rd_val = gwin;
		if (hit(s_axi_araddr, `ATG_OFF_SRES_HI))
			rd_val = cctl[`ATG_C_TOUCH]
			       ? {6'h00, x_axis, 6'h00, y_axis}
			       : {single_busy, 5'h00, sres[3], 6'h00, sres[2]};
		if (hit(s_axi_araddr, `ATG_OFF_SRES_LO))
			rd_val = {single_busy, 5'h00, sres[1], 6'h00, sres[0]};
		if (hit(s_axi_araddr, `ATG_OFF_CRES))
			rd_val = cres;
		if (hit(s_axi_araddr, `ATG_OFF_SETTLE))
			rd_val = {12'h000, settle};
		if (hit(s_axi_araddr, `ATG_OFF_IRQ))
			rd_val = {22'h000000, !dma_valid, irq_en, flags};
	end

	//--------------------------------------------------------------
	// register file
	//--------------------------------------------------------------
	// byte lanes of the stored word replaced by the strobed write data
	always_comb begin
		wr_merged = 32'h00000000;
		for (int b = 0; b < 4; b++) begin
			wr_merged[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8]
			                                  : 8'h00;
		end
	end

	// control registers; start and soft reset are one-cycle pulses
	always_ff @(posedge aclk) begin
		if (rst) begin
			timing  <= `ATG_RST_TIMING;
			halt    <= 1'b0;
			start_q <= 1'b0;
			smask   <= 4'h0;
			cctl    <= 8'h00;
			xwin    <= `ATG_RST_WIN;
			ywin    <= `ATG_RST_WIN;
			gwin    <= `ATG_RST_GWIN;
			settle  <= `ATG_RST_SETTLE;
			irq_en  <= 4'h0;
		end else begin
			start_q <= 1'b0;
			if (wr_do && w_strb_q[0] && hit(aw_addr_q, `ATG_OFF_SCTL)) begin
				halt    <= w_data_q[`ATG_S_HALT];
				start_q <= w_data_q[`ATG_S_START];
				smask   <= w_data_q[3:0];
			end
			if (wr_do && w_strb_q[0] && hit(aw_addr_q, `ATG_OFF_CCTL))
				cctl <= w_data_q[7:0];
			if (wr_do && hit(aw_addr_q, `ATG_OFF_TIMING))
				timing <= (timing & ~mask_of(w_strb_q)) | wr_merged;
			if (wr_do && hit(aw_addr_q, `ATG_OFF_XWIN))
				xwin <= ((xwin & ~mask_of(w_strb_q)) | wr_merged)
				        & 32'h03ff03ff;
			if (wr_do && hit(aw_addr_q, `ATG_OFF_YWIN))
				ywin <= ((ywin & ~mask_of(w_strb_q)) | wr_merged)
				        & 32'h03ff03ff;
			if (wr_do && hit(aw_addr_q, `ATG_OFF_GWIN))
				gwin <= ((gwin & ~mask_of(w_strb_q)) | wr_merged)
				        & 32'h03ff03ff;
			if (wr_do && hit(aw_addr_q, `ATG_OFF_SETTLE))
				settle <= 20'((({12'h000, settle} & ~mask_of(w_strb_q))
				              | wr_merged));
			if (wr_do && w_strb_q[1] && hit(aw_addr_q, `ATG_OFF_IRQ))
				irq_en[3] <= w_data_q[8];
			if (wr_do && w_strb_q[0] && hit(aw_addr_q, `ATG_OFF_IRQ))
				irq_en[2:0] <= w_data_q[7:5];
		end
	end

	function automatic logic [31:0] mask_of(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// soft reset pulse, cleared by hardware on the next edge
	always_ff @(posedge aclk) begin
		if (!aresetn)
			soft_q <= 1'b0;
		else
			soft_q <= !soft_q && wr_do && w_strb_q[0]
			          && hit(aw_addr_q, `ATG_OFF_SCTL)
			          && w_data_q[`ATG_S_SRST];
	end

	//--------------------------------------------------------------
	// conversion clock and continuous interval
	//--------------------------------------------------------------
	// divisor of zero or one gives a tick every system clock
	assign tick = 12'(div_cnt + 12'h001) >= timing[`ATG_DIV_HI:`ATG_DIV_LO];

	always_ff @(posedge aclk) begin
		if (rst)
			div_cnt <= 12'h000;
		else
			div_cnt <= tick ? 12'h000 : 12'(div_cnt + 12'h001);
	end

	// a round due while singles run stays due, so it is late, never lost
	always_ff @(posedge aclk) begin
		if (rst || halt || !cctl[`ATG_C_RUN]) begin
			gap_cnt <= 20'h00000;
			due     <= 1'b0;
		end else if (due_take) begin
			due <= 1'b0;
		end else if (!due && tick) begin
			if (gap_cnt >= timing[`ATG_GAP_HI:0]) begin
				gap_cnt <= 20'h00000;
				due     <= 1'b1;
			end else begin
				gap_cnt <= 20'(gap_cnt + 20'h00001);
			end
		end
	end

	//--------------------------------------------------------------
	// converter sequencer
	//--------------------------------------------------------------
	// touch rounds read X on channel 0, Y on channel 1 or on channel 2
	assign round_mask = !cctl[`ATG_C_TOUCH] ? cctl[3:0]
	                  : cctl[`ATG_C_FIVE] ? 4'h5 : 4'h3;
	assign due_take   = state == atg_pkg::SEQ_IDLE && c_left == 4'h0
	                  && s_pend == 4'h0 && due;
	assign start_set  = start_q ? smask : 4'h0;
	assign single_busy = s_pend != 4'h0
	                  || (state != atg_pkg::SEQ_IDLE && !job_cont);

	// continuous round first, then pending singles between rounds
	always_ff @(posedge aclk) begin
		if (rst || halt) begin
			state    <= atg_pkg::SEQ_IDLE;
			s_pend   <= 4'h0;
			c_left   <= 4'h0;
			job_cont <= 1'b0;
			conv_req <= '0;
		end else begin
			conv_req.power <= 1'b1;
			conv_req.clk   <= tick;
			conv_req.start <= 1'b0;
			s_pend <= s_pend | start_set;
			case (state)
				atg_pkg::SEQ_IDLE: begin
					if (c_left != 4'h0) begin
						conv_req.chan <= low_chan(c_left);
						c_left[low_chan(c_left)] <= 1'b0;
						job_cont <= 1'b1;
						state    <= atg_pkg::SEQ_START;
					end else if (s_pend != 4'h0) begin
						conv_req.chan <= low_chan(s_pend);
						s_pend   <= (s_pend | start_set)
						            & ~(4'h1 << low_chan(s_pend));
						job_cont <= 1'b0;
						state    <= atg_pkg::SEQ_START;
					end else if (due_take) begin
						c_left <= round_mask;
					end
				end
				atg_pkg::SEQ_START: begin
					if (tick) begin
						conv_req.start <= 1'b1;
						state          <= atg_pkg::SEQ_WAIT;
					end
				end
				atg_pkg::SEQ_WAIT: begin
					if (cap)
						state <= atg_pkg::SEQ_IDLE;
				end
				default: state <= atg_pkg::SEQ_IDLE;
			endcase
			if (!cctl[`ATG_C_RUN])
				c_left <= 4'h0;
		end
		if (!rst && halt)
			conv_req.clk <= tick;
	end

	// done crosses three flops; a level counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (rst) begin
			done_s    <= 3'h0;
			done_lvl  <= 1'b0;
			done_prev <= 1'b0;
		end else begin
			done_s    <= {done_s[1:0], conv_done};
			done_prev <= done_lvl;
			if (done_s[1] == done_s[2])
				done_lvl <= done_s[2];
		end
	end
	// the macro holds its data stable while done is high
	assign cap       = state == atg_pkg::SEQ_WAIT && done_lvl && !done_prev;
	assign round_end = cap && job_cont && c_left == 4'h0;

	//--------------------------------------------------------------
	// result capture, packing and DMA word
	//--------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (rst) begin
			for (int i = 0; i < 4; i++)
				sres[i] <= 10'h000;
			pack_lo   <= 10'h000;
			half      <= 1'b0;
			cres      <= 32'h00000000;
			dma_data  <= 32'h00000000;
			dma_valid <= 1'b0;
			x_axis    <= 10'h000;
			y_axis    <= 10'h000;
			raw_touch <= 1'b0;
		end else begin
			if (dma_valid && dma_ready)
				dma_valid <= 1'b0;
			if (due_take)
				half <= 1'b0;
			if (cap && !job_cont)
				sres[conv_req.chan] <= conv_data;
			if (cap && job_cont && cctl[`ATG_C_TOUCH]) begin
				if (conv_req.chan == 2'h0)
					x_axis <= conv_data;
				else
					y_axis <= conv_data;
			end
			// touch rounds update coordinates and the raw touch state, never the DMA word
			if (round_end && cctl[`ATG_C_TOUCH])
				raw_touch <= in_win(x_axis_n(), xwin)
				             && in_win(y_axis_n(), ywin);
			if (cap && job_cont && !cctl[`ATG_C_TOUCH]) begin
				if (half || c_left == 4'h0) begin
					cres      <= half ? {6'h00, conv_data, 6'h00, pack_lo}
					                  : {22'h000000, conv_data};
					dma_data  <= half ? {6'h00, conv_data, 6'h00, pack_lo}
					                  : {22'h000000, conv_data};
					dma_valid <= 1'b1;
					half      <= 1'b0;
				end else begin
					pack_lo <= conv_data;
					half    <= 1'b1;
				end
			end
		end
	end

	// coordinate as it stands after this capture
	function automatic logic [9:0] x_axis_n();
		return conv_req.chan == 2'h0 ? conv_data : x_axis;
	endfunction
	function automatic logic [9:0] y_axis_n();
		return conv_req.chan == 2'h0 ? y_axis : conv_data;
	endfunction
	function automatic logic in_win(input logic [9:0] v,
	                                input logic [31:0] w);
		return v >= w[`ATG_LO_HI:0] && v <= w[`ATG_HI_HI:`ATG_HI_LO];
	endfunction

	//--------------------------------------------------------------
	// touch debounce and status flags
	//--------------------------------------------------------------
	// a changed touch state must hold settle system clocks to be accepted
	always_ff @(posedge aclk) begin
		if (rst) begin
			pressed    <= 1'b0;
			settle_cnt <= 20'h00000;
		end else if (raw_touch == pressed) begin
			settle_cnt <= 20'h00000;
		end else if (settle_cnt >= settle) begin
			pressed    <= raw_touch;
			settle_cnt <= 20'h00000;
		end else begin
			settle_cnt <= 20'(settle_cnt + 20'h00001);
		end
	end

	// flags: full, over, under, up, down
	always_comb begin
		flag_set    = 5'h00;
		flag_set[4] = cap && job_cont && !cctl[`ATG_C_TOUCH]
		              && (half || c_left == 4'h0)
		              && dma_valid && !dma_ready;
		flag_set[3] = cap && cctl[`ATG_C_GUARD]
		              && conv_data > gwin[`ATG_HI_HI:`ATG_HI_LO];
		flag_set[2] = cap && cctl[`ATG_C_GUARD]
		              && conv_data < gwin[`ATG_LO_HI:0];
		flag_set[1] = pressed && raw_touch == 1'b0
		              && settle_cnt >= settle;
		flag_set[0] = !pressed && raw_touch && settle_cnt >= settle;
		flag_clr    = (wr_do && w_strb_q[0] && hit(aw_addr_q, `ATG_OFF_IRQ))
		              ? w_data_q[4:0] : 5'h00;
	end

	// a set in the cycle of its clear wins
	always_ff @(posedge aclk) begin
		if (rst) begin
			flags <= 5'h00;
			irq   <= 1'b0;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
			irq   <= |(flags & {irq_en[3], irq_en[2], irq_en[2],
			                    irq_en[1], irq_en[0]});
		end
	end

	//--------------------------------------------------------------
	// assertions
	//--------------------------------------------------------------
	a_halt_no_start: assert property (@(posedge aclk)
		disable iff (rst) halt |=> !conv_req.start && !conv_req.power)
		else $error("conversion started while halted");
	a_soft_clears: assert property (@(posedge aclk)
		disable iff (!aresetn) soft_q |=> !soft_q)
		else $error("soft reset bit stuck");
	a_start_pulse: assert property (@(posedge aclk)
		disable iff (rst) start_q |=> !start_q)
		else $error("start bit not cleared");
	a_busy_on_start: assert property (@(posedge aclk)
		disable iff (rst) start_q && smask != 4'h0 && !halt
		|=> single_busy)
		else $error("busy not set after start");
	a_start_on_tick: assert property (@(posedge aclk)
		disable iff (rst) conv_req.start |-> $past(tick))
		else $error("start not aligned to conversion clock");
	a_guard_over: assert property (@(posedge aclk)
		disable iff (rst) cap && cctl[`ATG_C_GUARD]
		&& conv_data > gwin[25:16] |=> flags[3])
		else $error("guard over flag missed");
	a_dma_hold: assert property (@(posedge aclk)
		disable iff (rst) dma_valid && !dma_ready && !cap
		|=> dma_valid && $stable(dma_data))
		else $error("dma word dropped");
	// software may clear the flag one cycle after it sets, so only the set
	a_full_flag: assert property (@(posedge aclk)
		disable iff (rst) flag_set[4] |=> flags[4])
		else $error("fifo full flag not set");
	a_irq_masked: assert property (@(posedge aclk)
		disable iff (rst) irq_en == 4'h0 ##1 irq_en == 4'h0 |-> !irq)
		else $error("masked interrupt raised");

endmodule // atg_controller
`default_nettype wire

// file: testbench/atg_macro_model.sv
// behavioural converter macro answering each start strobe
`timescale 1ns/100ps
`default_nettype none
module atg_macro_model (
	input  wire logic                   aclk,
	input  wire atg_pkg::atg_conv_req_s conv_req,
	output logic                        conv_done,
	output logic [9:0]                  conv_data
);
	logic [2:0] wait_cnt = 3'h0;
	initial conv_done = 1'b0;
	initial conv_data = 10'h000;
	// data is scrambled while busy, so a stale capture shows up
	always @(posedge aclk) begin
		if (conv_req.start) begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			wait_cnt  <= 3'h5;
		end else if (wait_cnt != 3'h0) begin
			wait_cnt <= wait_cnt - 3'h1;
			if (wait_cnt == 3'h1) conv_done <= 1'b1;
			if (wait_cnt == 3'h1) conv_data <= {conv_req.chan, 8'ha5};
		end
	end
endmodule // atg_macro_model
`default_nettype wire

// file: testbench/test_atg_controller.sv
// self-checking bench for the ADC controller
`timescale 1ns/100ps
`default_nettype none
module test_atg_controller;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, conv_done, dma_valid, irq, dma_ready = 1;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_rdata, dma_data;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [9:0]  conv_data;
	atg_pkg::atg_conv_req_s conv_req;
	int miscompares = 0, comparisons = 0, cyc = 0;
	localparam logic [31:0] base = 32'hbfe74000;
	atg_controller atg_controller_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_req,
		.conv_done, .conv_data, .dma_data, .dma_valid, .dma_ready, .irq);
	atg_macro_model atg_macro_model_inst (.aclk, .conv_req, .conv_done,
		.conv_data);
	always #20 aclk = ~aclk;
	// a hang is cut short and counted
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares++;
			summarize();
		end
	end
	function automatic logic [9:0] fv(input logic [1:0] c);
		return {c, 8'ha5};
	endfunction
	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one AXI4-Lite transfer; readiness sampled mid-cycle, released after
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [33:0] q);
		logic ta, tw, tr, done;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		do begin
			@(negedge aclk);
			ta = s_axi_awready & s_axi_awvalid;
			tw = s_axi_wready & s_axi_wvalid;
			tr = s_axi_arready & s_axi_arvalid;
			done = w ? s_axi_bvalid : s_axi_rvalid;
			q = w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tr) s_axi_arvalid <= 1'b0;
		end while (done !== 1'b1);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [33:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [31:0] a, input logic [33:0] e);
		logic [33:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic dw(input logic [31:0] e);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (dma_valid !== 1'b1 && n < 3000);
		chk({2'b00, dma_data}, {2'b00, e});
		@(posedge aclk);
	endtask
	task automatic t_reset();
		rd(base, {2'b00, 32'h00400010});
		rd(base + 32'h10, {2'b00, 32'h03ff0000});
		rd(base + 32'h18, {2'b00, 32'h03f0000f});
		rd(base + 32'h2c, {2'b00, 32'h00000640});
		rd(base + 32'h30, {2'b00, 32'h00000200});
		rd(base + 32'h0c, {2'b10, 32'h00000000});
	endtask
	// all four channels in one request, busy seen then cleared
	task automatic t_single();
		logic [33:0] q;
		int n;
		wr(base, 32'h00200003);
		wr(base + 32'h04, 32'h0000001f);
		xfer(1'b0, base + 32'h24, 32'h0, q);
		chk({33'h0, q[31]}, 34'h1);
		for (n = 0; n < 300 && q[31] !== 1'b0; n++) xfer(1'b0, base + 32'h24, 32'h0, q);
		chk(q, {8'h0, fv(1), 6'h0, fv(0)});
		rd(base + 32'h20, {8'h0, fv(3), 6'h0, fv(2)});
		rd(base + 32'h04, {2'b00, 32'h0000000f});
	endtask
	// channels 0,1,3 with guard bounds that ch0 undercuts and ch3 exceeds
	task automatic t_cont();
		wr(base + 32'h18, {6'h0, 10'h300, 6'h0, 10'h100});
		wr(base + 32'h08, 32'h0000009b);
		dw({6'h0, fv(1), 6'h0, fv(0)});
		dw({22'h0, fv(3)});
		// dma stalls: the in-flight ch3 word overwrites and flags full
		dma_ready <= 1'b0;
		dw({6'h0, fv(1), 6'h0, fv(0)});
		wr(base + 32'h08, 32'h0);
		repeat (30) @(posedge aclk);
		chk({2'b00, dma_data}, {24'h0, fv(3)});
		dma_ready <= 1'b1;
		wr(base + 32'h30, 32'h00000080);
		rd(base + 32'h30, {2'b00, 32'h0000029c});
		chk({33'h0, irq}, 34'h1);
		wr(base + 32'h30, 32'h0000009c);
		rd(base + 32'h30, {2'b00, 32'h00000280});
		chk({33'h0, irq}, 34'h0);
	endtask
	// four-wire touch: default windows take the press, a raised X min releases
	task automatic t_touch();
		wr(base + 32'h2c, 32'h00000010);
		wr(base + 32'h30, 32'h00000020);
		wr(base + 32'h08, 32'h000000c0);
		repeat (200) @(posedge aclk);
		rd(base + 32'h20, {8'h0, fv(0), 6'h0, fv(1)});
		rd(base + 32'h30, {2'b00, 32'h00000221});
		chk({33'h0, irq}, 34'h1);
		wr(base + 32'h10, 32'h03ff03ff);
		repeat (200) @(posedge aclk);
		rd(base + 32'h30, {2'b00, 32'h00000223});
		wr(base + 32'h08, 32'h0);
	endtask
	// halt powers down; soft reset restores registers and lifts the halt
	task automatic t_halt();
		chk({33'h0, conv_req.power}, 34'h1);
		wr(base + 32'h04, 32'h00000040);
		@(negedge aclk);
		chk({33'h0, conv_req.power}, 34'h0);
		wr(base + 32'h04, 32'h00000020);
		rd(base + 32'h04, {2'b00, 32'h00000000});
		rd(base + 32'h10, {2'b00, 32'h03ff0000});
		chk({33'h0, conv_req.power}, 34'h1);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_single();
		t_cont();
		t_touch();
		t_halt();
		summarize();
	end
endmodule // test_atg_controller
`default_nettype wire
